// >>> rtl/scc_clock_ctrl.sv
// System clock mode controller: clock select, gear, stabilization, standby
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
module scc_clock_ctrl
   import scc_pkg::*;
#(
   parameter logic [1:0] WAIT_OPTION = WAIT_OPTION_DEF,
   parameter logic [TB_SEL_W-1:0] WAIT_BIT0 = WAIT_BIT0_DEF,
   parameter logic [TB_SEL_W-1:0] WAIT_BIT1 = WAIT_BIT1_DEF,
   parameter logic [TB_SEL_W-1:0] WAIT_BIT2 = WAIT_BIT2_DEF,
   parameter logic [TB_SEL_W-1:0] WAIT_BIT3 = WAIT_BIT3_DEF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register port
   input wire scc_bus_s bus,
   output logic [7:0] rdata,
   // Oscillator periods, one pulse each
   input wire logic mainOscTick,
   input wire logic subOscTick,
   // Reset taken from sub-stop, caught after release
   input wire logic subStopReset,
   // Standby requests and wake sources
   input wire scc_stby_s stby,
   input wire scc_wake_s wake,
   // Clock outputs and status
   output scc_ticks_s ticks,
   output logic mainOscEnable,
   output logic subOscEnable,
   output logic cpuHold,
   output logic clockModeMonitor
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   scc_state_s stateReg;
   scc_state_s stateNext;

   logic wrHit;
   logic rdHit;
   logic mainRunning;
   logic mainGated;
   logic mainDivTick;
   logic subCpuTick;
   logic tbClear;
   logic wpClear;
   logic tbOvf;
   logic wpOvf;
   logic tbTickIn;
   logic wpTickIn;
   logic [TB_SEL_W-1:0] tbSel;
   logic [TB_W-1:0] tbCount;
   logic [7:0] readValue;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [GEAR_CNT_W-1:0] gearTerm(input logic [1:0] g);
      case (g)
         GEAR_DIV4: return TERM_DIV4;
         GEAR_DIV8: return TERM_DIV8;
         GEAR_DIV16: return TERM_DIV16;
         default: return TERM_DIV64;
      endcase
   endfunction

   function automatic logic [TB_SEL_W-1:0] waitBit(input logic [1:0] w);
      case (w)
         2'h0: return WAIT_BIT0;
         2'h1: return WAIT_BIT1;
         2'h2: return WAIT_BIT2;
         default: return WAIT_BIT3;
      endcase
   endfunction

   function automatic logic isSubMode(input scc_mode_e m);
      return (m == ST_SUB_RUN) || (m == ST_SUB_SLEEP) || (m == ST_SUB_STOP) ||
         (m == ST_WATCH);
   endfunction

   assign wrHit = bus.wr && (bus.addr == SYSCLK_CTRL_OFS);
   assign rdHit = bus.rd && (bus.addr == SYSCLK_CTRL_OFS);
   assign tbSel = waitBit(stateReg.waitSel);

   // ----------------------------------------------------------------
   // Oscillator and clock gating
   // ----------------------------------------------------------------
   // Main oscillator off in subclock modes and main stop
   assign mainRunning = !isSubMode(stateReg.mode) && (stateReg.mode != ST_MAIN_STOP);
   assign mainOscEnable = mainRunning;
   assign subOscEnable = (stateReg.mode != ST_SUB_STOP);
   assign mainGated = mainOscTick && mainRunning;
   assign cpuHold = (stateReg.mode == ST_RESET) || (stateReg.mode == ST_SUBSTAB) ||
      (stateReg.mode == ST_MAINSTAB);
   assign mainDivTick = mainGated && (stateReg.gearCnt == gearTerm(stateReg.gear));
   assign subCpuTick = subOscTick && stateReg.subDiv;
   assign tbTickIn = mainGated;
   assign wpTickIn = subOscTick && subOscEnable;
   assign clockModeMonitor = stateReg.mainMode;
   assign rdata = stateReg.rdata;

   // Reserved pair reads as zero, monitor from mode flag
   assign readValue = {stateReg.mainMode, UNUSED_READ, stateReg.waitSel,
      stateReg.clockSel, stateReg.gear};

   always_comb begin
      ticks.cpu = 1'b0;
      ticks.periph = 1'b0;
      case (stateReg.mode)
         ST_MAIN_RUN: begin
            ticks.cpu = mainDivTick;
            ticks.periph = mainDivTick;
         end
         ST_MAIN_SLEEP: begin
            ticks.periph = mainDivTick;
         end
         ST_SUB_RUN: begin
            ticks.cpu = subCpuTick;
            ticks.periph = subOscTick;
         end
         ST_SUB_SLEEP: begin
            ticks.periph = subOscTick;
         end
         default: begin
            ticks.cpu = 1'b0;
         end
      endcase
      // Gear-independent timebase and watch clocks
      ticks.timebase = tbTickIn && tbCount[0];
      ticks.watch = wpTickIn;
   end

   // ----------------------------------------------------------------
   // Stabilization counters
   // ----------------------------------------------------------------
   scc_prescaler #(
      .W(TB_W),
      .SEL_W(TB_SEL_W)
   ) u_timebase (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(tbTickIn),
      .clear(tbClear),
      .ovfSel(tbSel),
      .count(tbCount),
      .ovf(tbOvf)
   );

   scc_prescaler #(
      .W(WP_W),
      .SEL_W(WP_SEL_W)
   ) u_watch_prescaler (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(wpTickIn),
      .clear(wpClear),
      .ovfSel(WP_STAB_BIT),
      .count(),
      .ovf(wpOvf)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      stateNext = stateReg;
      stateNext.rdata = rdHit ? readValue : RDATA_IDLE;
      if (wrHit) begin
         // Monitor and unused positions are not stored
         stateNext.waitSel = bus.wdata[WAIT_HI:WAIT_LO];
         stateNext.clockSel = bus.wdata[SEL_BIT];
         stateNext.gear = bus.wdata[GEAR_HI:GEAR_LO];
      end
      if (mainGated && (stateReg.mode == ST_MAIN_RUN || stateReg.mode == ST_MAIN_SLEEP)) begin
         // Wrap also when a gear change leaves the count past the new terminal
         stateNext.gearCnt = (stateReg.gearCnt >= gearTerm(stateReg.gear)) ? '0 :
            stateReg.gearCnt + {{(GEAR_CNT_W-1){1'b0}}, 1'b1};
      end
      if (subOscTick) begin
         stateNext.subDiv = !stateReg.subDiv;
      end
      case (stateReg.mode)
         ST_RESET: begin
            // Strap seen after release decides the first wait
            stateNext.mode = subStopReset ? ST_SUBSTAB : ST_MAINSTAB;
         end
         ST_SUBSTAB: begin
            if (wpOvf) begin
               stateNext.mode = stateReg.mainMode ? ST_MAINSTAB : ST_SUB_RUN;
            end
         end
         ST_MAINSTAB: begin
            if (wrHit && !bus.wdata[SEL_BIT] && !stateReg.mainMode) begin
               stateNext.mode = ST_SUB_RUN;
            end else if (tbOvf) begin
               stateNext.mode = ST_MAIN_RUN;
               stateNext.mainMode = 1'b1;
            end
         end
         ST_MAIN_RUN: begin
            if (wrHit && !bus.wdata[SEL_BIT]) begin
               stateNext.mode = ST_SUB_RUN;
               stateNext.mainMode = 1'b0;
            end else if (stby.stop) begin
               stateNext.mode = ST_MAIN_STOP;
            end else if (stby.sleep) begin
               stateNext.mode = ST_MAIN_SLEEP;
            end
         end
         ST_MAIN_SLEEP: begin
            if (wake.anyIrq) begin
               stateNext.mode = ST_MAIN_RUN;
            end
         end
         ST_MAIN_STOP: begin
            if (wake.extIrq) begin
               stateNext.mode = ST_MAINSTAB;
            end
         end
         ST_SUB_RUN: begin
            if (wrHit && bus.wdata[SEL_BIT]) begin
               stateNext.mode = ST_MAINSTAB;
            end else if (stby.stop) begin
               stateNext.mode = ST_SUB_STOP;
            end else if (stby.watch) begin
               stateNext.mode = ST_WATCH;
            end else if (stby.sleep) begin
               stateNext.mode = ST_SUB_SLEEP;
            end
         end
         ST_SUB_SLEEP: begin
            if (wake.anyIrq) begin
               stateNext.mode = ST_SUB_RUN;
            end
         end
         ST_SUB_STOP: begin
            if (wake.extIrq) begin
               stateNext.mode = ST_SUBSTAB;
            end
         end
         ST_WATCH: begin
            if (wake.extIrq || wake.watchIrq) begin
               stateNext.mode = ST_SUB_RUN;
            end
         end
         default: begin
            stateNext.mode = ST_RESET;
         end
      endcase
   end

   // Counters restart on entry into a wait
   assign tbClear = (stateNext.mode == ST_MAINSTAB) && (stateReg.mode != ST_MAINSTAB);
   assign wpClear = (stateNext.mode == ST_SUBSTAB) && (stateReg.mode != ST_SUBSTAB);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stateReg.mode <= ST_RESET;
         stateReg.waitSel <= WAIT_OPTION;
         stateReg.clockSel <= SEL_RESET;
         stateReg.gear <= GEAR_RESET;
         stateReg.mainMode <= 1'b1;
         stateReg.gearCnt <= '0;
         stateReg.subDiv <= 1'b0;
         stateReg.rdata <= RDATA_IDLE;
      end else begin
         stateReg <= stateNext;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Whether the previous sub tick gave the CPU a cycle in sub run
   logic subCpuLast;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         subCpuLast <= 1'b0;
      end else if (subOscTick) begin
         subCpuLast <= ticks.cpu && (stateReg.mode == ST_SUB_RUN);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_mon_readback: assert property (rdHit |=> rdata[MON_BIT] == $past(stateReg.mainMode))
      else $error("monitor bit readback wrong");
   a_mon_sub: assert property (isSubMode(stateReg.mode) |-> !clockModeMonitor)
      else $error("monitor high in subclock mode");
   a_mon_nowrite: assert property (wrHit && stateReg.mode == ST_SUB_RUN && !bus.wdata[SEL_BIT]
      |=> !clockModeMonitor)
      else $error("monitor bit took written value");
   a_unused_read: assert property (rdHit |=> rdata[UNUSED_HI:UNUSED_LO] == UNUSED_READ)
      else $error("unused bits not zero");
   a_wait_write: assert property (wrHit |=> stateReg.waitSel == $past(bus.wdata[WAIT_HI:WAIT_LO]))
      else $error("wait field not stored");
   a_sub_switch: assert property (stateReg.mode == ST_MAIN_RUN && wrHit && !bus.wdata[SEL_BIT]
      |=> stateReg.mode == ST_SUB_RUN && !mainOscEnable)
      else $error("no switch to subclock");
   a_no_early: assert property (stateReg.mode == ST_MAINSTAB && !tbOvf && !wrHit
      |=> stateReg.mode == ST_MAINSTAB)
      else $error("main clock before stabilization");
   a_main_switch: assert property (stateReg.mode == ST_MAINSTAB && tbOvf && !wrHit
      |=> stateReg.mode == ST_MAIN_RUN && clockModeMonitor)
      else $error("monitor not set on switch to main");
   a_gear_tick: assert property (ticks.cpu && stateReg.mode == ST_MAIN_RUN
      |-> stateReg.gearCnt == gearTerm(stateReg.gear))
      else $error("cpu tick off gear count");
   a_sub_cycle: assert property (subOscTick && stateReg.mode == ST_SUB_RUN && subCpuLast
      |-> !ticks.cpu)
      else $error("sub cycle wrong");
   a_stop_quiet: assert property ((stateReg.mode == ST_MAIN_STOP || stateReg.mode == ST_SUB_STOP ||
      stateReg.mode == ST_WATCH) |-> !ticks.cpu && !ticks.periph && !ticks.timebase)
      else $error("clock runs in stop or watch");
   a_sleep_wake: assert property (stateReg.mode == ST_MAIN_SLEEP && wake.anyIrq
      |=> stateReg.mode == ST_MAIN_RUN)
      else $error("sleep not ended by interrupt");
   a_watch_entry: assert property (stateReg.mode == ST_MAIN_RUN |=> stateReg.mode != ST_WATCH)
      else $error("watch entered from main");
   a_reset_path: assert property (stateReg.mode == ST_RESET
      |=> stateReg.mode == ST_SUBSTAB || stateReg.mode == ST_MAINSTAB)
      else $error("reset did not start a wait");
   a_tb_clear: assert property (tbClear |=> tbCount == '0)
      else $error("timebase not cleared");

   c_to_sub: cover property (stateReg.mode == ST_MAIN_RUN ##1 stateReg.mode == ST_SUB_RUN);
   c_to_main: cover property (stateReg.mode == ST_MAINSTAB ##1 stateReg.mode == ST_MAIN_RUN);
   c_watch: cover property (stateReg.mode == ST_WATCH ##1 stateReg.mode == ST_SUB_RUN);
   c_substop_reset: cover property (stateReg.mode == ST_SUBSTAB ##1 stateReg.mode == ST_MAINSTAB);

endmodule

// >>> rtl/scc_pkg.sv
// Shared constants, types and state layout of the system clock controller
package scc_pkg;

   // ----------------------------------------------------------------
   // Register map and field layout
   // ----------------------------------------------------------------
   localparam int REG_ADDR_W = 1;
   localparam logic [REG_ADDR_W-1:0] SYSCLK_CTRL_OFS = 1'h0;
   localparam int MON_BIT = 7;
   localparam int UNUSED_HI = 6;
   localparam int UNUSED_LO = 5;
   localparam int WAIT_HI = 4;
   localparam int WAIT_LO = 3;
   localparam int SEL_BIT = 2;
   localparam int GEAR_HI = 1;
   localparam int GEAR_LO = 0;
   localparam logic [1:0] UNUSED_READ = 2'h0;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] WAIT_OPTION_DEF = 2'h3;
   localparam logic SEL_RESET = 1'b1;
   localparam logic [1:0] GEAR_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Gear codes and divider terminal counts
   // ----------------------------------------------------------------
   localparam logic [1:0] GEAR_DIV4 = 2'h3;
   localparam logic [1:0] GEAR_DIV8 = 2'h2;
   localparam logic [1:0] GEAR_DIV16 = 2'h1;
   localparam logic [1:0] GEAR_DIV64 = 2'h0;
   localparam int GEAR_CNT_W = 6;
   localparam logic [GEAR_CNT_W-1:0] TERM_DIV4 = 6'h03;
   localparam logic [GEAR_CNT_W-1:0] TERM_DIV8 = 6'h07;
   localparam logic [GEAR_CNT_W-1:0] TERM_DIV16 = 6'h0f;
   localparam logic [GEAR_CNT_W-1:0] TERM_DIV64 = 6'h3f;

   // ----------------------------------------------------------------
   // Prescaler sizes and stabilization bit choices
   // ----------------------------------------------------------------
   localparam int TB_W = 19;
   localparam int TB_SEL_W = 5;
   localparam int WP_W = 15;
   localparam int WP_SEL_W = 4;
   localparam logic [WP_SEL_W-1:0] WP_STAB_BIT = 4'he;
   localparam logic [TB_SEL_W-1:0] WAIT_BIT0_DEF = 5'h0c;
   localparam logic [TB_SEL_W-1:0] WAIT_BIT1_DEF = 5'h0e;
   localparam logic [TB_SEL_W-1:0] WAIT_BIT2_DEF = 5'h10;
   localparam logic [TB_SEL_W-1:0] WAIT_BIT3_DEF = 5'h12;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_SUBSTAB = 4'h1,
      ST_MAINSTAB = 4'h2,
      ST_MAIN_RUN = 4'h3,
      ST_MAIN_SLEEP = 4'h4,
      ST_MAIN_STOP = 4'h5,
      ST_SUB_RUN = 4'h6,
      ST_SUB_SLEEP = 4'h7,
      ST_SUB_STOP = 4'h8,
      ST_WATCH = 4'h9
   } scc_mode_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [REG_ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } scc_bus_s;

   typedef struct packed {
      logic sleep;
      logic stop;
      logic watch;
   } scc_stby_s;

   typedef struct packed {
      logic anyIrq;
      logic extIrq;
      logic watchIrq;
   } scc_wake_s;

   typedef struct packed {
      logic cpu;
      logic periph;
      logic timebase;
      logic watch;
   } scc_ticks_s;

   typedef struct packed {
      scc_mode_e mode;
      logic [1:0] waitSel;
      logic clockSel;
      logic [1:0] gear;
      logic mainMode;
      logic [GEAR_CNT_W-1:0] gearCnt;
      logic subDiv;
      logic [7:0] rdata;
   } scc_state_s;

endpackage

// >>> rtl/scc_prescaler.sv
// Free-running prescaler with clear and selectable overflow bit
`timescale 1ns/1ns
module scc_prescaler
   import scc_pkg::*;
#(
   parameter int W = TB_W,
   parameter int SEL_W = TB_SEL_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Counting
   input wire logic tick,
   input wire logic clear,
   input wire logic [SEL_W-1:0] ovfSel,
   // Status
   output logic [W-1:0] count,
   output logic ovf
);

   logic [W-1:0] cntReg;
   logic [W-1:0] cntNext;

   function automatic logic [W-1:0] lowMask(input logic [SEL_W-1:0] sel);
      logic [W-1:0] m;
      m = '0;
      for (int i = 0; i < W; i++) begin
         m[i] = (i <= int'(sel));
      end
      return m;
   endfunction

   // Overflow of the chosen bit: all bits up to it set while a tick arrives
   assign ovf = tick && (&(cntReg | ~lowMask(ovfSel)));
   assign count = cntReg;

   always_comb begin
      cntNext = cntReg;
      if (clear) begin
         cntNext = '0;
      end else if (tick) begin
         cntNext = cntReg + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cntReg <= '0;
      end else begin
         cntReg <= cntNext;
      end
   end

endmodule

// >>> test/scc_clock_ctrl_tb.sv
// Self-checking bench for the system clock controller
`timescale 1ns/1ns
module scc_clock_ctrl_tb
   import scc_pkg::*;
;
   localparam int W = 256;
   localparam int SUB = 4;
   localparam logic [7:0] RST_REG = {1'b1, 2'b00, WAIT_OPTION_DEF, 1'b1, 2'b00};
   int DIV[4] = '{64, 16, 8, 4};
   int WB[4] = '{2, 3, 4, 5};
   logic clk_sys;
   logic resetn;
   scc_bus_s bus;
   logic [7:0] rdata;
   logic mainOscTick, subOscTick, subStopReset, clr, fastSub;
   scc_stby_s stby;
   scc_wake_s wake;
   scc_ticks_s ticks;
   logic mainOscEnable, subOscEnable, cpuHold, clockModeMonitor;
   logic [15:0] cpuCnt, perCnt, tbCnt, wCnt;
   int miscompares = 0;
   int checks = 0;
   int n;

   scc_clock_ctrl #(.WAIT_BIT0(5'h02), .WAIT_BIT1(5'h03), .WAIT_BIT2(5'h04),
      .WAIT_BIT3(5'h05)) scc_clock_ctrl_i (
      .clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata(rdata),
      .mainOscTick(mainOscTick), .subOscTick(subOscTick), .subStopReset(subStopReset),
      .stby(stby), .wake(wake), .ticks(ticks), .mainOscEnable(mainOscEnable),
      .subOscEnable(subOscEnable), .cpuHold(cpuHold), .clockModeMonitor(clockModeMonitor));

   scc_clock_partner #(.SUB_PER(SUB)) scc_clock_partner_i (
      .clk_sys(clk_sys), .mainOscEnable(mainOscEnable), .subOscEnable(subOscEnable),
      .fastSub(fastSub),
      .mainOscTick(mainOscTick), .subOscTick(subOscTick), .ticks(ticks), .clr(clr),
      .cpuCnt(cpuCnt), .perCnt(perCnt), .tbCnt(tbCnt), .wCnt(wCnt));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic inr(input string name, input int v, input int lo, input int hi);
      chk(name, {31'h0, v >= lo && v <= hi}, 32'h1);
   endtask

   // Tick count over a window of W cycles against a period in cycles
   task automatic rate(input string name, input int seen, input int per);
      int e;
      e = (per == 0) ? 0 : W / per;
      inr(name, seen, e - 1, e + 1);
   endtask

   task automatic wr_reg(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [REG_ADDR_W-1:0] a, input logic [7:0] exp,
         input string name);
      @(posedge clk_sys);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      chk(name, rdata, exp);
   endtask

   task automatic meas();
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (W) @(posedge clk_sys);
      #1;
   endtask

   task automatic pulse(input scc_stby_s s);
      @(posedge clk_sys);
      stby <= s;
      @(posedge clk_sys);
      stby <= '0;
   endtask

   task automatic wakeup(input scc_wake_s w);
      @(posedge clk_sys);
      wake <= w;
      repeat (4) @(posedge clk_sys);
      wake <= '0;
   endtask

   // Cycles until the CPU runs on the main clock again
   task automatic wait_run(output int c);
      c = 0;
      while ((cpuHold !== 1'b0 || clockModeMonitor !== 1'b1) && c < 1000) begin
         @(posedge clk_sys);
         #1;
         c++;
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      // Two waits of 2^15 fast sub ticks plus a few thousand cycles of tests
      repeat (80000) @(posedge clk_sys);
      miscompares++;
      print_verdict();
   end

   initial begin
      resetn = 1'b0;
      bus = '0;
      stby = '0;
      wake = '0;
      subStopReset = 1'b0;
      clr = 1'b0;
      fastSub = 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rd_reg(SYSCLK_CTRL_OFS, RST_REG, "reg reset");
      @(posedge clk_sys);
      #1;
      chk("rdata idle", rdata, RDATA_IDLE);
      wr_reg(1'b1, 8'h00);
      rd_reg(1'b1, 8'h00, "unmapped");
      wait_run(n);
      inr("reset wait", n, 40, 72);
      // Gear codes, with monitor and unused bits written against their read value
      for (int g = 0; g < 4; g++) begin
         wr_reg(SYSCLK_CTRL_OFS, {3'b011, 2'b00, 1'b1, 2'(g)});
         rd_reg(SYSCLK_CTRL_OFS, {3'b100, 2'b00, 1'b1, 2'(g)}, "reg gear");
         meas();
         rate("cpu gear", cpuCnt, DIV[g]);
         rate("periph gear", perCnt, DIV[g]);
         rate("timebase", tbCnt, 2);
         rate("watch", wCnt, SUB);
      end
      // Let the subclock settle before the first switch to it
      @(posedge clk_sys);
      fastSub <= 1'b1;
      repeat (32768) @(posedge clk_sys);
      fastSub <= 1'b0;
      // Main to sub and back for every wait code
      for (int c = 0; c < 4; c++) begin
         wr_reg(SYSCLK_CTRL_OFS, {3'b000, 2'(c), 1'b1, 2'b11});
         wr_reg(SYSCLK_CTRL_OFS, {3'b000, 2'(c), 1'b0, 2'b11});
         repeat (2) @(posedge clk_sys);
         #1;
         chk("monitor sub", clockModeMonitor, 1'b0);
         chk("main osc off", mainOscEnable, 1'b0);
         meas();
         rate("cpu sub", cpuCnt, 2 * SUB);
         rate("periph sub", perCnt, SUB);
         rate("timebase sub", tbCnt, 0);
         wr_reg(SYSCLK_CTRL_OFS, {3'b000, 2'(c), 1'b1, 2'b11});
         #1;
         chk("monitor wait", clockModeMonitor, 1'b0);
         wait_run(n);
         inr("main wait", n, (2 << WB[c]) - 3, (2 << WB[c]) + 4);
         chk("monitor main", clockModeMonitor, 1'b1);
      end
      // Main sleep, ignored watch, main stop
      pulse('{sleep: 1'b1, stop: 1'b0, watch: 1'b0});
      meas();
      rate("cpu sleep", cpuCnt, 0);
      rate("periph sleep", perCnt, 4);
      wakeup('{anyIrq: 1'b1, extIrq: 1'b0, watchIrq: 1'b0});
      pulse('{sleep: 1'b0, stop: 1'b0, watch: 1'b1});
      meas();
      rate("cpu woken", cpuCnt, 4);
      pulse('{sleep: 1'b0, stop: 1'b1, watch: 1'b0});
      wakeup('{anyIrq: 1'b1, extIrq: 1'b0, watchIrq: 1'b0});
      meas();
      chk("main osc stop", mainOscEnable, 1'b0);
      rate("periph stop", perCnt, 0);
      rate("watch stop", wCnt, SUB);
      wakeup('{anyIrq: 1'b0, extIrq: 1'b1, watchIrq: 1'b0});
      wait_run(n);
      inr("stop wait", n, 50, 72);
      // Watch and sleep from sub mode
      wr_reg(SYSCLK_CTRL_OFS, {3'b000, 2'b11, 1'b0, 2'b11});
      pulse('{sleep: 1'b0, stop: 1'b0, watch: 1'b1});
      meas();
      rate("cpu watch", cpuCnt, 0);
      rate("periph watch", perCnt, 0);
      rate("watch run", wCnt, SUB);
      wakeup('{anyIrq: 1'b0, extIrq: 1'b0, watchIrq: 1'b1});
      pulse('{sleep: 1'b1, stop: 1'b0, watch: 1'b0});
      meas();
      rate("cpu subsleep", cpuCnt, 0);
      rate("periph subsleep", perCnt, SUB);
      wakeup('{anyIrq: 1'b1, extIrq: 1'b0, watchIrq: 1'b0});
      meas();
      rate("cpu subwake", cpuCnt, 2 * SUB);
      // Reset from sub mode
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rd_reg(SYSCLK_CTRL_OFS, RST_REG, "reg re-reset");
      wait_run(n);
      chk("main after reset", mainOscEnable, 1'b1);
      // Sub-stop, then a reset out of it waits on the watch prescaler first
      wr_reg(SYSCLK_CTRL_OFS, {3'b000, 2'b11, 1'b0, 2'b11});
      pulse('{sleep: 1'b0, stop: 1'b1, watch: 1'b0});
      meas();
      chk("sub osc stop", subOscEnable, 1'b0);
      rate("watch substop", wCnt, 0);
      rate("cpu substop", cpuCnt, 0);
      @(posedge clk_sys);
      fastSub <= 1'b1;
      subStopReset <= 1'b1;
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (32700) @(posedge clk_sys);
      #1;
      chk("sub wait hold", cpuHold, 1'b1);
      wait_run(n);
      inr("sub wait", n, 120, 145);
      print_verdict();
   end
endmodule

// >>> test/scc_clock_partner.sv
// Oscillator sources and tick receivers around the clock controller
`timescale 1ns/1ns
module scc_clock_partner
   import scc_pkg::*;
#(
   parameter int SUB_PER = 4
) (
   // Clock
   input wire logic clk_sys,
   // Oscillators
   input wire logic mainOscEnable,
   input wire logic subOscEnable,
   input wire logic fastSub,
   output logic mainOscTick,
   output logic subOscTick,
   // Tick receivers
   input wire scc_ticks_s ticks,
   input wire logic clr,
   output logic [15:0] cpuCnt,
   output logic [15:0] perCnt,
   output logic [15:0] tbCnt,
   output logic [15:0] wCnt
);
   int subPh = 0;

   // Each oscillator ticks only while enabled
   assign mainOscTick = mainOscEnable;
   // Fast mode ticks the subclock every cycle to shorten the long waits
   assign subOscTick = subOscEnable && (fastSub || subPh == SUB_PER - 1);

   always_ff @(posedge clk_sys) begin
      subPh <= subOscEnable ? (subPh + 1) % SUB_PER : 0;
   end

   always_ff @(posedge clk_sys) begin
      if (clr) begin
         cpuCnt <= '0;
         perCnt <= '0;
         tbCnt <= '0;
         wCnt <= '0;
      end else begin
         cpuCnt <= cpuCnt + 16'(ticks.cpu);
         perCnt <= perCnt + 16'(ticks.periph);
         tbCnt <= tbCnt + 16'(ticks.timebase);
         wCnt <= wCnt + 16'(ticks.watch);
      end
   end
endmodule
